/* rtl/pcs_pkg.sv */
/*
 * Shared constants and carrier types of the program counter sequencer:
 * register offset, vectors, widths and the decoder command format.
 * Assumes a single 10 MHz system clock domain for every user.
 */
package pcs_pkg;

   // ----------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------
   localparam int PC_MAX_W = 11;
   localparam int PC_MIN_W = 9;
   localparam int INSTR_W = 14;
   localparam int PHASES = 4;
   localparam int STACK_DEPTH = 2;
   localparam int LOW_BYTE_W = 8;

   // ----------------------------------------------------------------
   // register map and vectors
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_PCL_ADDR = 8'h06;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [10:0] VEC_RESET = 11'h000;
   localparam logic [10:0] VEC_EXT = 11'h004;
   localparam logic [10:0] VEC_TMR = 11'h008;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_SEQ,
      OP_JUMP,
      OP_CALL,
      OP_RET,
      OP_INTERRUPT_RETURN_OP,
      OP_SKIP
   } pcs_op_type;

   // what the decoder says about the instruction in execute
   typedef struct packed {
      pcs_op_type op;
      logic skip_hit;
      logic [10:0] target;
   } pcs_cmd_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pcs_reg_req_type;

endpackage

/* rtl/pcs_phase_gen.sv */
/*
 * Divides the system clock into the four phases of an instruction cycle.
 * Assumes one clock; the end-of-cycle output is a one-cycle enable.
 */
`timescale 1ns/1ps
module pcs_phase_gen #(
   parameter int PHASES = pcs_pkg::PHASES
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic [$clog2(PHASES)-1:0] phase,
   output logic cycle_end
);
   localparam int PW = $clog2(PHASES);
   localparam logic [PW-1:0] LAST = PW'(PHASES - 1);

   if (PHASES < 2) begin : g_bad_phases
      $error("pcs_phase_gen: PHASES must be at least 2");
   end

   typedef struct packed {
      logic [PW-1:0] phase;
   } pcs_phase_state_type;

   pcs_phase_state_type state_reg;
   pcs_phase_state_type state_next;

   always_comb begin
      state_next = state_reg;
      if (state_reg.phase == LAST) begin
         state_next.phase = '0;
      end else begin
         state_next.phase = state_reg.phase + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign phase = state_reg.phase;
   assign cycle_end = (state_reg.phase == LAST);
endmodule // pcs_phase_gen

/* rtl/pcs_ret_stack.sv */
/*
 * Return-address stack. A push onto a full stack drops the oldest entry.
 * Assumes push and pop are never asked in the same cycle.
 */
`timescale 1ns/1ps
module pcs_ret_stack #(
   parameter int W = pcs_pkg::PC_MAX_W,
   parameter int DEPTH = pcs_pkg::STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [W-1:0] push_data,
   output logic [W-1:0] top,
   output logic full,
   output logic empty
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   if (DEPTH < 1) begin : g_bad_depth
      $error("pcs_ret_stack: DEPTH must be at least 1");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] entry;
      logic [CW-1:0] count;
   } pcs_stack_state_type;

   pcs_stack_state_type state_reg;
   pcs_stack_state_type state_next;

   always_comb begin
      state_next = state_reg;
      if (push) begin
         // shift down; the oldest falls off the end when full
         for (int i = DEPTH - 1; i > 0; i--) begin
            state_next.entry[i] = state_reg.entry[i-1];
         end
         state_next.entry[0] = push_data;
         if (state_reg.count != CNT_FULL) begin
            state_next.count = state_reg.count + 1'b1;
         end
      end else if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            state_next.entry[i] = state_reg.entry[i+1];
         end
         if (state_reg.count != '0) begin
            state_next.count = state_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign top = state_reg.entry[0];
   assign full = (state_reg.count == CNT_FULL);
   assign empty = (state_reg.count == '0);
endmodule // pcs_ret_stack

/* rtl/pcs_sequencer.sv */
/*
 * Program counter sequencer: four-phase instruction cycle, two-stage
 * fetch/execute pipeline, instruction pointer update and the low byte
 * register at 06h.
 * Assumes a same-clock decoder that presents its command for the
 * instruction in execute by the last phase, a program memory that
 * answers combinationally to the fetch address, and an interrupt
 * controller that holds its request until acknowledged.
 */
// The implementer's own choice: the address-and-strobe port.
// Notes on behaviour
// - four phases make one instruction cycle
// - next fetch overlaps current execute
// - pointer changes cost one dummy cycle
// - pointer advances by one after fetch
// - transfers load the proper target address
// - taken skip discards the prefetched instruction
// - low byte readable and writable at 06h
// - low byte write jumps within 256 words
// - reset starts execution at address zero
// - interrupt vectors 004h external, 008h timer
// - pointer width 9, 10 or 11
// - returns reload the saved address
`timescale 1ns/1ps
module pcs_sequencer #(
   parameter int PC_W = pcs_pkg::PC_MAX_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire pcs_pkg::pcs_reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   output logic [PC_W-1:0] rom_addr,
   input wire logic [pcs_pkg::INSTR_W-1:0] rom_data,
   output logic [pcs_pkg::INSTR_W-1:0] ir_word,
   output logic [PC_W-1:0] ir_addr,
   output logic ir_valid,
   output logic [1:0] phase,
   output logic cycle_end,
   input wire pcs_pkg::pcs_cmd_type cmd,
   input wire logic irq_ext_req,
   input wire logic irq_tmr_req,
   output logic irq_ack_ext,
   output logic irq_ack_tmr,
   output logic interrupt_return_op_done
);
   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   if (PC_W < pcs_pkg::PC_MIN_W || PC_W > pcs_pkg::PC_MAX_W) begin : g_bad_pc_w
      $error("pcs_sequencer: PC_W must be 9, 10 or 11");
   end

   localparam int LB = pcs_pkg::LOW_BYTE_W;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [pcs_pkg::INSTR_W-1:0] ir_word;
      logic [PC_W-1:0] ir_addr;
      logic ir_valid;
      logic pcl_pend;
      logic [LB-1:0] pcl_val;
      logic [7:0] rdata;
      logic ack_ext;
      logic ack_tmr;
      logic interrupt_return_op;
   } pcs_seq_state_type;

   pcs_seq_state_type state_reg;
   pcs_seq_state_type state_next;

   logic push;
   logic pop;
   logic [PC_W-1:0] stack_top;
   logic stack_full;
   logic pcl_hit;
   logic [LB-1:0] pcl_data;
   logic pcl_wr_now;
   logic take_irq;
   logic seq_path;
   pcs_pkg::pcs_op_type exec_op;

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   pcs_phase_gen #(
      .PHASES(pcs_pkg::PHASES)
   ) u_phase (
      .clk(clk),
      .rst_n(rst_n),
      .phase(phase),
      .cycle_end(cycle_end)
   );

   pcs_ret_stack #(
      .W(PC_W),
      .DEPTH(pcs_pkg::STACK_DEPTH)
   ) u_stack (
      .clk(clk),
      .rst_n(rst_n),
      .push(push),
      .pop(pop),
      .push_data(state_reg.pc),
      .top(stack_top),
      .full(stack_full),
      .empty()
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   assign pcl_wr_now = reg_req.wr && (reg_req.addr == pcs_pkg::REG_PCL_ADDR);
   // a write in the boundary cycle itself is not lost
   assign pcl_hit = state_reg.pcl_pend || pcl_wr_now;
   assign pcl_data = pcl_wr_now ? reg_req.wdata : state_reg.pcl_val;
   // a dummy cycle executes nothing, so its command is ignored
   assign exec_op = state_reg.ir_valid ? cmd.op : pcs_pkg::OP_SEQ;
   assign seq_path = cycle_end && (exec_op == pcs_pkg::OP_SEQ);
   // stack full: the request waits until a return frees a level
   assign take_irq = seq_path && !pcl_hit && !stack_full && (irq_ext_req || irq_tmr_req);

   always_comb begin
      state_next = state_reg;
      state_next.rdata = pcs_pkg::RDATA_RESET;
      state_next.ack_ext = 1'b0;
      state_next.ack_tmr = 1'b0;
      state_next.interrupt_return_op = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      // executing instruction's own address, as software expects
      if (reg_req.rd && reg_req.addr == pcs_pkg::REG_PCL_ADDR) begin
         state_next.rdata = 8'(state_reg.ir_addr[LB-1:0]);
      end
      if (pcl_wr_now) begin
         state_next.pcl_pend = 1'b1;
         state_next.pcl_val = reg_req.wdata;
      end
      if (cycle_end) begin
         // fetch of the next word overlaps execute of the current one
         state_next.ir_word = rom_data;
         state_next.ir_addr = state_reg.pc;
         state_next.ir_valid = 1'b1;
         state_next.pc = state_reg.pc + 1'b1;
         state_next.pcl_pend = 1'b0;
         unique case (exec_op)
            pcs_pkg::OP_JUMP: begin
               state_next.pc = cmd.target[PC_W-1:0];
               state_next.ir_valid = 1'b0;
            end
            pcs_pkg::OP_CALL: begin
               push = 1'b1;
               state_next.pc = cmd.target[PC_W-1:0];
               state_next.ir_valid = 1'b0;
            end
            pcs_pkg::OP_RET, pcs_pkg::OP_INTERRUPT_RETURN_OP: begin
               pop = 1'b1;
               state_next.pc = stack_top;
               state_next.ir_valid = 1'b0;
               state_next.interrupt_return_op = (exec_op == pcs_pkg::OP_INTERRUPT_RETURN_OP);
            end
            pcs_pkg::OP_SKIP: begin
               // pointer still advances, so the net step is two words
               if (cmd.skip_hit) begin
                  state_next.ir_valid = 1'b0;
               end
            end
            pcs_pkg::OP_SEQ: begin
               if (pcl_hit) begin
                  state_next.pc = {state_reg.pc[PC_W-1:LB], pcl_data};
                  state_next.ir_valid = 1'b0;
               end else if (take_irq) begin
                  // saves the address of the word being discarded
                  push = 1'b1;
                  state_next.ir_valid = 1'b0;
                  if (irq_ext_req) begin
                     state_next.pc = pcs_pkg::VEC_EXT[PC_W-1:0];
                     state_next.ack_ext = 1'b1;
                  end else begin
                     state_next.pc = pcs_pkg::VEC_TMR[PC_W-1:0];
                     state_next.ack_tmr = 1'b1;
                  end
               end
            end
            default: begin
               // illegal decoder code: plain sequential fetch
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.pc <= pcs_pkg::VEC_RESET[PC_W-1:0];
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata = state_reg.rdata;
   assign rom_addr = state_reg.pc;
   assign ir_word = state_reg.ir_word;
   assign ir_addr = state_reg.ir_addr;
   assign ir_valid = state_reg.ir_valid;
   assign irq_ack_ext = state_reg.ack_ext;
   assign irq_ack_tmr = state_reg.ack_tmr;
   assign interrupt_return_op_done = state_reg.interrupt_return_op;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_cycle_four_clocks: assert property (
      @(posedge clk) disable iff (!rst_n)
      cycle_end |=> (!cycle_end) [*3] ##1 cycle_end)
      else $error("instruction cycle is not four clocks");

   a_pc_held_midcycle: assert property (
      @(posedge clk) disable iff (!rst_n)
      !cycle_end |=> $stable(state_reg.pc) && $stable(state_reg.ir_addr))
      else $error("pointer moved inside an instruction cycle");

   a_fetch_increment: assert property (
      @(posedge clk) disable iff (!rst_n)
      seq_path && !pcl_hit && !take_irq
      |=> state_reg.pc == $past(state_reg.pc) + 1'b1 && state_reg.ir_valid)
      else $error("pointer did not advance by one after fetch");

   a_jump_dummy: assert property (
      @(posedge clk) disable iff (!rst_n)
      cycle_end && state_reg.ir_valid && cmd.op == pcs_pkg::OP_JUMP
      |=> state_reg.pc == $past(cmd.target[PC_W-1:0]) && !state_reg.ir_valid
          ##4 state_reg.ir_valid)
      else $error("jump did not load target and insert one dummy cycle");

   a_skip_discard: assert property (
      @(posedge clk) disable iff (!rst_n)
      cycle_end && state_reg.ir_valid && cmd.op == pcs_pkg::OP_SKIP && cmd.skip_hit
      |=> !state_reg.ir_valid && state_reg.pc == $past(state_reg.pc) + 1'b1)
      else $error("taken skip did not discard the prefetched word");

   a_pcl_read_back: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_req.rd && reg_req.addr == pcs_pkg::REG_PCL_ADDR
      |=> reg_rdata == 8'($past(state_reg.ir_addr[LB-1:0])))
      else $error("low byte read returned the wrong value");

   a_pcl_short_jump: assert property (
      @(posedge clk) disable iff (!rst_n)
      seq_path && pcl_hit
      |=> state_reg.pc[LB-1:0] == $past(pcl_data)
          && state_reg.pc[PC_W-1:LB] == $past(state_reg.pc[PC_W-1:LB]))
      else $error("low byte write did not jump inside the current block");

   a_irq_vector: assert property (
      @(posedge clk) disable iff (!rst_n)
      take_irq |=> irq_ack_ext || irq_ack_tmr ##0
      (state_reg.pc == (irq_ack_ext ? pcs_pkg::VEC_EXT[PC_W-1:0]
                                    : pcs_pkg::VEC_TMR[PC_W-1:0])))
      else $error("interrupt did not load its vector");

   a_return_reload: assert property (
      @(posedge clk) disable iff (!rst_n)
      cycle_end && state_reg.ir_valid
      && (cmd.op == pcs_pkg::OP_RET || cmd.op == pcs_pkg::OP_INTERRUPT_RETURN_OP)
      |=> state_reg.pc == $past(stack_top) && !state_reg.ir_valid)
      else $error("return did not reload the saved address");

   a_call_push: assert property (
      @(posedge clk) disable iff (!rst_n)
      cycle_end && state_reg.ir_valid && cmd.op == pcs_pkg::OP_CALL
      |=> state_reg.pc == $past(cmd.target[PC_W-1:0]) && !state_reg.ir_valid
          && stack_top == $past(state_reg.pc))
      else $error("call did not load target or save the return address");

   a_skip_miss: assert property (
      @(posedge clk) disable iff (!rst_n)
      cycle_end && state_reg.ir_valid && cmd.op == pcs_pkg::OP_SKIP && !cmd.skip_hit
      |=> state_reg.ir_valid && state_reg.pc == $past(state_reg.pc) + 1'b1)
      else $error("skip with false condition did not continue in sequence");

   a_irq_save_addr: assert property (
      @(posedge clk) disable iff (!rst_n)
      take_irq |=> stack_top == $past(state_reg.pc) && !state_reg.ir_valid)
      else $error("interrupt did not save the discarded address");

   a_irq_ext_first: assert property (
      @(posedge clk) disable iff (!rst_n)
      take_irq && irq_ext_req
      |=> irq_ack_ext && !irq_ack_tmr && state_reg.pc == pcs_pkg::VEC_EXT[PC_W-1:0])
      else $error("external request did not win over the timer");

   a_interrupt_return_op_signal: assert property (
      @(posedge clk) disable iff (!rst_n)
      cycle_end && state_reg.ir_valid && cmd.op == pcs_pkg::OP_INTERRUPT_RETURN_OP
      |=> interrupt_return_op_done ##1 !interrupt_return_op_done)
      else $error("interrupt return pulse missing or too long");

   // no disable: meant to run while reset is low; one edge of slack for power-up
   a_reset_vector: assert property (
      @(posedge clk)
      !rst_n |=> state_reg.pc == pcs_pkg::VEC_RESET[PC_W-1:0] && !state_reg.ir_valid)
      else $error("reset did not clear the pointer");

endmodule // pcs_sequencer

/* dv/pcs_rom_model.sv */
/*
 * Program memory model: one 14-bit word per address, answered at once.
 * Assumes the sequencer holds the fetch address over the whole cycle.
 */
`timescale 1ns/1ps
module pcs_rom_model #(
   parameter int PC_W = 11
) (
   input wire logic [PC_W-1:0] rom_addr,
   output logic [pcs_pkg::INSTR_W-1:0] rom_data
);
   // word carries its own address so a wrong fetch shows up in ir_word
   always_comb begin
      rom_data = {3'h5, 11'(rom_addr)};
   end
endmodule // pcs_rom_model

/* dv/pcs_sequencer_tb_top.sv */
/*
 * Self-checking bench of the program counter sequencer.
 * Assumes the program memory model beside it; decoder and interrupt
 * requests are played by the bench.
 */
`timescale 1ns/1ps
module pcs_sequencer_tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   typedef struct packed {
      pcs_pkg::pcs_op_type op;
      logic hit;
      logic [7:0] wa;
      logic [10:0] tgt;
      logic [10:0] exp;
      logic dmy;
   } pcs_row_type;
   localparam pcs_pkg::pcs_cmd_type cmd_idle = '{op: pcs_pkg::OP_SEQ, skip_hit: 1'b0,
                                                 target: 11'h000};
   logic clk = 1'b0;
   logic rst_n;
   pcs_pkg::pcs_reg_req_type reg_req;
   pcs_pkg::pcs_cmd_type cmd;
   logic irq_ext_req;
   logic irq_tmr_req;
   logic [7:0] reg_rdata;
   logic [10:0] rom_addr;
   logic [13:0] rom_data;
   logic [13:0] ir_word;
   logic [10:0] ir_addr;
   logic ir_valid;
   logic [1:0] phase;
   logic cycle_end;
   logic irq_ack_ext;
   logic irq_ack_tmr;
   logic interrupt_return_op_done;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   // a write row carries its data in tgt
   pcs_row_type rows [12] = '{
      '{pcs_pkg::OP_SEQ, 1'b0, 8'h00, 11'h000, 11'h001, 1'b0},
      '{pcs_pkg::OP_JUMP, 1'b0, 8'h00, 11'h100, 11'h100, 1'b1},
      '{pcs_pkg::OP_SKIP, 1'b1, 8'h00, 11'h000, 11'h102, 1'b1},
      '{pcs_pkg::OP_SKIP, 1'b0, 8'h00, 11'h000, 11'h103, 1'b0},
      '{pcs_pkg::OP_CALL, 1'b0, 8'h00, 11'h200, 11'h200, 1'b1},
      '{pcs_pkg::OP_CALL, 1'b0, 8'h00, 11'h300, 11'h300, 1'b1},
      '{pcs_pkg::OP_RET, 1'b0, 8'h00, 11'h000, 11'h201, 1'b1},
      '{pcs_pkg::OP_INTERRUPT_RETURN_OP, 1'b0, 8'h00, 11'h000, 11'h104, 1'b1},
      '{pcs_pkg::OP_SEQ, 1'b0, 8'h06, 11'h040, 11'h140, 1'b1},
      '{pcs_pkg::OP_JUMP, 1'b0, 8'h00, 11'h7ff, 11'h7ff, 1'b1},
      '{pcs_pkg::OP_SEQ, 1'b0, 8'h00, 11'h000, 11'h000, 1'b0},
      '{pcs_pkg::OP_JUMP, 1'b0, 8'h00, 11'h2a5, 11'h2a5, 1'b1}};

   pcs_sequencer #(.PC_W(11)) uut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .rom_addr(rom_addr), .rom_data(rom_data), .ir_word(ir_word),
      .ir_addr(ir_addr), .ir_valid(ir_valid), .phase(phase), .cycle_end(cycle_end),
      .cmd(cmd), .irq_ext_req(irq_ext_req), .irq_tmr_req(irq_tmr_req),
      .irq_ack_ext(irq_ack_ext), .irq_ack_tmr(irq_ack_tmr), .interrupt_return_op_done(interrupt_return_op_done));
   pcs_rom_model #(.PC_W(11)) rom (.rom_addr(rom_addr), .rom_data(rom_data));

   // ----------------------------------------------------------------
   // clock, timeout, tasks
   // ----------------------------------------------------------------
   always #50 clk = ~clk;
   // whole run is well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // wait for the next instruction boundary; c counts cycles from phase 0
   task automatic bnd(output int c);
      c = 0;
      @(negedge clk);
      while (cycle_end !== 1'b1 && c < 8) begin
         @(negedge clk);
         c++;
      end
      @(posedge clk);
      cmd <= cmd_idle;
      #1;
   endtask

   task automatic step(input pcs_row_type r);
      int c;
      @(posedge clk);
      if (r.wa != 8'h00) begin
         reg_req <= '{addr: r.wa, wdata: r.tgt[7:0], wr: 1'b1, rd: 1'b0};
         @(posedge clk);
         reg_req.wr <= 1'b0;
      end else begin
         cmd <= '{op: r.op, skip_hit: r.hit, target: r.tgt};
      end
      bnd(c);
      chk(16'(phase), 16'h0000);
      if (r.dmy) begin
         chk(16'(ir_valid), 16'h0000);
         chk(16'(interrupt_return_op_done), 16'(r.op == pcs_pkg::OP_INTERRUPT_RETURN_OP));
         bnd(c);
         chk(16'(c), 16'h0003);
      end
      chk(16'(ir_valid), 16'h0001);
      chk(16'(ir_addr), 16'(r.exp));
      chk(16'(ir_word), 16'({3'h5, r.exp}));
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      reg_req.rd <= 1'b0;
      #1 chk(16'(reg_rdata), 16'(e));
      @(posedge clk);
      #1 chk(16'(reg_rdata), 16'h0000);
   endtask

   // the word fetched behind the interrupted one is what gets pushed
   task automatic irq_run(input logic ext, input logic [10:0] vec);
      int c;
      logic [10:0] last;
      last = ir_addr;
      @(posedge clk);
      irq_ext_req <= ext;
      irq_tmr_req <= !ext;
      for (int i = 0; i < 4 && (irq_ack_ext | irq_ack_tmr) !== 1'b1; i++) begin
         // settle first: the boundary edge that moves ir_addr is still in this step
         #1 last = ir_addr;
         bnd(c);
      end
      chk(16'(irq_ack_ext), 16'(ext));
      chk(16'(irq_ack_tmr), 16'(!ext));
      @(posedge clk);
      irq_ext_req <= 1'b0;
      irq_tmr_req <= 1'b0;
      bnd(c);
      chk(16'(ir_addr), 16'(vec));
      step('{pcs_pkg::OP_INTERRUPT_RETURN_OP, 1'b0, 8'h00, 11'h000, last + 11'h001, 1'b1});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      reg_req = '0;
      cmd = cmd_idle;
      irq_ext_req = 1'b0;
      irq_tmr_req = 1'b0;
      repeat (16) @(posedge clk);
      #1 chk(16'(rom_addr), 16'h0000);
      chk(16'(ir_valid), 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      // first instruction cycle after release is a dummy
      #1 chk(16'(ir_valid), 16'h0000);
      bnd(n);
      chk(16'(n), 16'h0003);
      chk(16'(ir_valid), 16'h0001);
      chk(16'(ir_addr), 16'h0000);
      chk(16'(ir_word), 16'h2800);
      for (int i = 0; i < 12; i++) begin
         step(rows[i]);
      end
      rd(8'h06, 8'ha5);
      bnd(n);
      // write off the mapped byte must not move the pointer
      step('{pcs_pkg::OP_SEQ, 1'b0, 8'h05, 11'h011, 11'h2a7, 1'b0});
      rd(8'h07, 8'h00);
      irq_run(1'b1, 11'h004);
      irq_run(1'b0, 11'h008);
      // reset in mid-run restarts the pointer at zero
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1 chk(16'(rom_addr), 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      bnd(n);
      chk(16'(ir_addr), 16'h0000);
      chk(16'(ir_valid), 16'h0001);
      wrap_up();
   end
endmodule // pcs_sequencer_tb_top
